/* inc/pgd_defs.svh */
// Constants of the partitioned graphics datapath.
// Assumes inclusion by bare name from inc/ on the search path.
// Functional notes
// - Graphics adder is four independent 16-bit or two 32-bit adder lanes.
// - Graphics multiplier is four separate 8-bit by 16-bit multipliers.
// - Graphics status register holds scale factor and alignment offset.
// - Pixel data is four unsigned bytes in a 32-bit word.
// - Pixel distance reads eight unsigned bytes per 64-bit register.
// - Fixed data: 4x16 or 2x32 in 64 bits, 2x16 or 1x32 in 32.
// - Lane-wise add and subtract with 16-bit or 32-bit lanes.
// - Seven partitioned multiply variants on 8-bit and 16-bit lanes.
// - Logic unit computes any of sixteen two-input bitwise functions.
// - Partial stores; 8 and 16-bit loads and stores to registers.
// - Pixel distance sums byte absolute differences into an accumulator.
// - All four lane products finish together; one multiply per cycle.
// - Pixel to fixed conversion yields 16-bit or 32-bit lanes.
// - Operands and results use a shared 32 by 64-bit register file.
// - Misaligned data handled using the status alignment offset.
// - Adder ops take one cycle; multiplier ops three, fully pipelined.
// - Two graphics ops and one load or store accepted every cycle.
`ifndef PGD_DEFS_SVH
`define PGD_DEFS_SVH
`define PGD_NREGS 32
`define PGD_NRD 6
`define PGD_GSR_ALIGN_LSB 0
`define PGD_GSR_ALIGN_MSB 2
`define PGD_GSR_SCALE_LSB 3
`define PGD_GSR_SCALE_MSB 6
`define PGD_GSR_RESET 7'h00
`define PGD_MUL_RND 25'h0000080
`define PGD_EXP_SHIFT 4
`define PGD_PACK_SHIFT 7
`define PGD_PIX_MAX 8'hff
`define PGD_RD_A1 0
`define PGD_RD_A2 1
`define PGD_RD_M1 2
`define PGD_RD_M2 3
`define PGD_RD_ACC 4
`define PGD_RD_ST 5
`endif

/* inc/pgd_pkg.sv */
// Types shared by the partitioned graphics datapath files.
// Assumes pgd_defs.svh is reachable on the include path.
`default_nettype none
package pgd_pkg;
  typedef enum logic [3:0] {
    PGD_ADD16 = 4'h0, PGD_ADD32 = 4'h1, PGD_SUB16 = 4'h2,
    PGD_SUB32 = 4'h3, PGD_LOGIC = 4'h4, PGD_ALIGN = 4'h5,
    PGD_ALIGNADDR = 4'h6, PGD_MERGE = 4'h7, PGD_EXPAND = 4'h8,
    PGD_CONV32 = 4'h9, PGD_WRGSR = 4'ha
  } pgd_add_op_t;
  typedef enum logic [3:0] {
    PGD_MUL8X16 = 4'h0, PGD_MUL8X16AU = 4'h1, PGD_MUL8X16AL = 4'h2,
    PGD_MUL8SUX16 = 4'h3, PGD_MUL8ULX16 = 4'h4, PGD_MULD8SUX16 = 4'h5,
    PGD_MULD8ULX16 = 4'h6, PGD_PDIST = 4'h7, PGD_PACK16 = 4'h8,
    PGD_CMPGT16 = 4'h9
  } pgd_mul_op_t;
  typedef enum logic [1:0] {
    PGD_SZ8 = 2'h0, PGD_SZ16 = 2'h1, PGD_SZ32 = 2'h2, PGD_SZ64 = 2'h3
  } pgd_size_t;
  typedef struct packed {
    logic valid;
    pgd_add_op_t op;
    logic [3:0] func;
    logic [4:0] rs1;
    logic [4:0] rs2;
    logic [4:0] rd;
  } pgd_add_req_t;
  typedef struct packed {
    logic valid;
    pgd_mul_op_t op;
    logic [4:0] rs1;
    logic [4:0] rs2;
    logic [4:0] rd;
  } pgd_mul_req_t;
  typedef struct packed {
    logic valid;
    logic store;
    pgd_size_t size;
    logic partial;
    logic [7:0] mask;
    logic [4:0] rg;
    logic [63:0] ld_data;
  } pgd_ls_req_t;
endpackage
`default_nettype wire

/* core/pgd_regfile.sv */
// Shared 32 by 64-bit register file with registered read ports.
// Assumes writers never target one entry twice in the same cycle.
`default_nettype none
`include "pgd_defs.svh"
module pgd_regfile
  import pgd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Read ports, data one cycle after address
  input wire logic [`PGD_NRD-1:0][4:0] raddr,
  output logic [`PGD_NRD-1:0][63:0] rdata,
  // Write ports, highest index wins on a clash
  input wire logic [2:0] wen,
  input wire logic [2:0][4:0] waddr,
  input wire logic [2:0][63:0] wdata
);
  logic [63:0] mem [`PGD_NREGS];

  always_ff @(posedge ref_clk) begin
    for (int w = 0; w < 3; w++) begin
      if (wen[w]) begin
        mem[waddr[w]] <= wdata[w];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      for (int r = 0; r < `PGD_NRD; r++) begin
        rdata[r] <= mem[raddr[r]];
      end
    end
  end
endmodule
`default_nettype wire

/* core/pgd_datapath.sv */
// Partitioned graphics datapath: adder slot, multiplier slot, load/store.
// Assumes issue logic avoids read-after-write hazards; no forwarding.
`default_nettype none
`include "pgd_defs.svh"
module pgd_datapath
  import pgd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Issue slots, all three may be valid together
  input wire pgd_add_req_t add_req,
  input wire pgd_mul_req_t mul_req,
  input wire pgd_ls_req_t ls_req,
  // Completion
  output logic add_done_q,
  output logic [63:0] add_res_q,
  output logic mul_done_q,
  output logic [63:0] mul_res_q,
  // Store data toward memory
  output logic st_valid_q,
  output logic [63:0] st_data_q,
  output logic [7:0] st_be_q,
  // Status register contents
  output logic [6:0] gsr_q
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] lane_addsub(logic [63:0] a, logic [63:0] b,
                                              logic sub, logic w32);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[16*i +: 16] = sub ? a[16*i +: 16] - b[16*i +: 16]
                          : a[16*i +: 16] + b[16*i +: 16];
    end
    if (w32) begin
      for (int i = 0; i < 2; i++) begin
        r[32*i +: 32] = sub ? a[32*i +: 32] - b[32*i +: 32]
                            : a[32*i +: 32] + b[32*i +: 32];
      end
    end
    return r;
  endfunction

  function automatic logic signed [24:0] mul8x16(logic [7:0] a, logic sa,
                                                 logic [15:0] b);
    logic signed [24:0] ax;
    logic signed [24:0] bx;
    // Widen first so the product is not cut to operand width
    ax = sa ? 25'($signed(a)) : 25'($signed({1'b0, a}));
    bx = 25'($signed(b));
    return ax * bx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [`PGD_NRD-1:0][4:0] raddr;
  logic [`PGD_NRD-1:0][63:0] rdata;
  logic [2:0] wen;
  logic [2:0][4:0] waddr;
  logic [2:0][63:0] wdata;
  logic [4:0] add_rd_q, ls_rg_q;
  logic [4:0] m1_rd_q, m2_rd_q, m3_rd_q;
  logic ld_wb_q;
  logic [63:0] ld_val_q;

  always_comb begin
    raddr = '0;
    raddr[`PGD_RD_A1] = add_req.rs1;
    raddr[`PGD_RD_A2] = add_req.rs2;
    raddr[`PGD_RD_M1] = mul_req.rs1;
    raddr[`PGD_RD_M2] = mul_req.rs2;
    raddr[`PGD_RD_ACC] = mul_req.rd;
    raddr[`PGD_RD_ST] = ls_req.rg;
  end

  assign wen = {add_done_q, mul_done_q, ld_wb_q};
  assign waddr = {add_rd_q, m3_rd_q, ls_rg_q};
  assign wdata = {add_res_q, mul_res_q, ld_val_q};

  pgd_regfile u_rf (
    .ref_clk(ref_clk),
    .rst(rst),
    .raddr(raddr),
    .rdata(rdata),
    .wen(wen),
    .waddr(waddr),
    .wdata(wdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operand stage: requests delayed to meet registered read data
  pgd_add_req_t add_e_q;
  pgd_mul_req_t mul_e_q;
  pgd_ls_req_t ls_e_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      add_e_q <= '0;
      mul_e_q <= '0;
      ls_e_q <= '0;
    end else begin
      add_e_q <= add_req;
      mul_e_q <= mul_req;
      ls_e_q <= ls_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Graphics adder, single cycle
  logic [63:0] a1, a2, add_d;
  logic [2:0] align;
  logic [3:0] scale;
  logic [63:0] addr_sum;

  assign a1 = rdata[`PGD_RD_A1];
  assign a2 = rdata[`PGD_RD_A2];
  assign align = gsr_q[`PGD_GSR_ALIGN_MSB:`PGD_GSR_ALIGN_LSB];
  assign scale = gsr_q[`PGD_GSR_SCALE_MSB:`PGD_GSR_SCALE_LSB];
  assign addr_sum = a1 + a2;

  always_comb begin
    logic [127:0] cat;
    add_d = '0;
    cat = {a1, a2} << {align, 3'h0};
    unique case (add_e_q.op)
      PGD_ADD16: add_d = lane_addsub(a1, a2, 1'b0, 1'b0);
      PGD_ADD32: add_d = lane_addsub(a1, a2, 1'b0, 1'b1);
      PGD_SUB16: add_d = lane_addsub(a1, a2, 1'b1, 1'b0);
      PGD_SUB32: add_d = lane_addsub(a1, a2, 1'b1, 1'b1);
      PGD_LOGIC: begin
        for (int i = 0; i < 64; i++) begin
          add_d[i] = add_e_q.func[{a1[i], a2[i]}];
        end
      end
      PGD_ALIGN: add_d = cat[127:64];
      PGD_ALIGNADDR: add_d = {addr_sum[63:3], 3'h0};
      PGD_MERGE: begin
        for (int i = 0; i < 4; i++) begin
          add_d[16*i +: 16] = {a1[8*i +: 8], a2[8*i +: 8]};
        end
      end
      PGD_EXPAND: begin
        for (int i = 0; i < 4; i++) begin
          add_d[16*i +: 16] =
            16'(a2[8*i +: 8]) << `PGD_EXP_SHIFT;
        end
      end
      PGD_CONV32: begin
        for (int i = 0; i < 2; i++) begin
          add_d[32*i +: 32] = 32'(a2[8*i +: 8]) << scale;
        end
      end
      PGD_WRGSR: add_d = '0;
      default: add_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      add_done_q <= 1'b0;
      add_res_q <= '0;
      add_rd_q <= '0;
    end else begin
      // Status writes leave the register file alone
      add_done_q <= add_e_q.valid && add_e_q.op != PGD_WRGSR;
      add_res_q <= add_d;
      add_rd_q <= add_e_q.rd;
    end
  end

  // Status register: scale and alignment fields
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gsr_q <= `PGD_GSR_RESET;
    end else if (add_e_q.valid && add_e_q.op == PGD_WRGSR) begin
      gsr_q <= a1[6:0];
    end else if (add_e_q.valid && add_e_q.op == PGD_ALIGNADDR) begin
      gsr_q[`PGD_GSR_ALIGN_MSB:`PGD_GSR_ALIGN_LSB] <= addr_sum[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Graphics multiplier, three stages, one issue per cycle
  logic [63:0] m1, m2;
  logic signed [24:0] prod [4];
  logic [7:0] ad [8];
  logic [63:0] early;
  logic signed [24:0] s1_prod_q [4];
  logic [7:0] s1_ad_q [8];
  logic [63:0] s1_early_q, s1_acc_q, s2_acc_q, s2_res_q;
  logic [10:0] s2_sum_q;
  pgd_mul_op_t s1_op_q, s2_op_q;
  logic s1_v_q, s2_v_q;

  assign m1 = mul_e_q.op == PGD_MUL8X16 || mul_e_q.op == PGD_MUL8X16AU ||
              mul_e_q.op == PGD_MUL8X16AL ? rdata[`PGD_RD_M1]
                                          : rdata[`PGD_RD_M1];
  assign m2 = rdata[`PGD_RD_M2];

  always_comb begin
    logic [7:0] sa_byte;
    logic [15:0] sb;
    logic signed [31:0] sh;
    sa_byte = '0;
    sb = '0;
    sh = '0;
    early = '0;
    for (int i = 0; i < 4; i++) begin
      unique case (mul_e_q.op)
        PGD_MUL8X16AU: prod[i] = mul8x16(m1[8*i +: 8], 1'b0, m2[31:16]);
        PGD_MUL8X16AL: prod[i] = mul8x16(m1[8*i +: 8], 1'b0, m2[15:0]);
        PGD_MUL8SUX16, PGD_MULD8SUX16:
          prod[i] = mul8x16(m1[16*i+8 +: 8], 1'b1, m2[16*i +: 16]);
        PGD_MUL8ULX16, PGD_MULD8ULX16:
          prod[i] = mul8x16(m1[16*i +: 8], 1'b0, m2[16*i +: 16]);
        default: prod[i] = mul8x16(m1[8*i +: 8], 1'b0, m2[16*i +: 16]);
      endcase
    end
    for (int j = 0; j < 8; j++) begin
      ad[j] = m1[8*j +: 8] > m2[8*j +: 8] ? m1[8*j +: 8] - m2[8*j +: 8]
                                          : m2[8*j +: 8] - m1[8*j +: 8];
    end
    for (int i = 0; i < 4; i++) begin
      sh = ($signed(m2[16*i +: 16]) <<< scale) >>> `PGD_PACK_SHIFT;
      sa_byte = sh < 0 ? 8'h00 : (sh > 32'sd255 ? `PGD_PIX_MAX : sh[7:0]);
      if (mul_e_q.op == PGD_PACK16) begin
        early[8*i +: 8] = sa_byte;
      end else begin
        early[i] = $signed(m1[16*i +: 16]) > $signed(m2[16*i +: 16]);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_v_q <= 1'b0;
      s2_v_q <= 1'b0;
      mul_done_q <= 1'b0;
    end else begin
      s1_v_q <= mul_e_q.valid;
      s2_v_q <= s1_v_q;
      mul_done_q <= s2_v_q;
    end
  end

  // Stage 1: four lane products, byte differences, pack and compare
  always_ff @(posedge ref_clk) begin
    s1_prod_q <= prod;
    s1_ad_q <= ad;
    s1_early_q <= early;
    s1_acc_q <= rdata[`PGD_RD_ACC];
    s1_op_q <= mul_e_q.op;
    m1_rd_q <= mul_e_q.rd;
  end

  // Stage 2: lane formatting with rounding, difference sum
  always_ff @(posedge ref_clk) begin
    logic [10:0] sum;
    logic [24:0] r;
    sum = '0;
    for (int j = 0; j < 8; j++) begin
      sum = sum + 11'(s1_ad_q[j]);
    end
    s2_sum_q <= sum;
    s2_res_q <= s1_early_q;
    for (int i = 0; i < 4; i++) begin
      r = s1_prod_q[i] + `PGD_MUL_RND;
      if (s1_op_q != PGD_MULD8SUX16 && s1_op_q != PGD_MULD8ULX16 &&
          s1_op_q != PGD_PACK16 && s1_op_q != PGD_CMPGT16 &&
          s1_op_q != PGD_PDIST) begin
        s2_res_q[16*i +: 16] <= r[23:8];
      end
    end
    // Wide variants use only lanes 0 and 1, each in a 32-bit slot
    if (s1_op_q == PGD_MULD8SUX16 || s1_op_q == PGD_MULD8ULX16) begin
      s2_res_q <= {s1_prod_q[1][23:0], 8'h00, s1_prod_q[0][23:0], 8'h00};
    end
    s2_acc_q <= s1_acc_q;
    s2_op_q <= s1_op_q;
    m2_rd_q <= m1_rd_q;
  end

  // Stage 3: accumulate pixel distance
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mul_res_q <= '0;
      m3_rd_q <= '0;
    end else begin
      mul_res_q <= s2_op_q == PGD_PDIST
                   ? s2_acc_q + {53'h0, s2_sum_q} : s2_res_q;
      m3_rd_q <= m2_rd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loads and stores
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ld_wb_q <= 1'b0;
      ld_val_q <= '0;
      ls_rg_q <= '0;
    end else begin
      ld_wb_q <= ls_req.valid && !ls_req.store;
      ls_rg_q <= ls_req.rg;
      unique case (ls_req.size)
        PGD_SZ8: ld_val_q <= {56'h0, ls_req.ld_data[7:0]};
        PGD_SZ16: ld_val_q <= {48'h0, ls_req.ld_data[15:0]};
        PGD_SZ32: ld_val_q <= {32'h0, ls_req.ld_data[31:0]};
        PGD_SZ64: ld_val_q <= ls_req.ld_data;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_valid_q <= 1'b0;
      st_data_q <= '0;
      st_be_q <= '0;
    end else begin
      st_valid_q <= ls_e_q.valid && ls_e_q.store;
      st_data_q <= rdata[`PGD_RD_ST];
      if (ls_e_q.partial) begin
        // Mask bit per lane; 16/32-bit lanes widen the enables
        unique case (ls_e_q.size)
          PGD_SZ16: st_be_q <= {{2{ls_e_q.mask[3]}}, {2{ls_e_q.mask[2]}},
                                {2{ls_e_q.mask[1]}}, {2{ls_e_q.mask[0]}}};
          PGD_SZ32: st_be_q <= {{4{ls_e_q.mask[1]}}, {4{ls_e_q.mask[0]}}};
          default: st_be_q <= ls_e_q.mask;
        endcase
      end else begin
        unique case (ls_e_q.size)
          PGD_SZ8: st_be_q <= 8'h01;
          PGD_SZ16: st_be_q <= 8'h03;
          PGD_SZ32: st_be_q <= 8'h0f;
          PGD_SZ64: st_be_q <= 8'hff;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* tb/pgd_dp_properties.sv */
// Port checker for the partitioned graphics datapath top module.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module pgd_dp_properties
  import pgd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Issue slots
  input wire pgd_add_req_t add_req,
  input wire pgd_mul_req_t mul_req,
  input wire pgd_ls_req_t ls_req,
  // Results
  input wire logic add_done_q,
  input wire logic [63:0] add_res_q,
  input wire logic mul_done_q,
  input wire logic [63:0] mul_res_q,
  input wire logic st_valid_q,
  input wire logic [63:0] st_data_q,
  input wire logic [7:0] st_be_q,
  input wire logic [6:0] gsr_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_add_lat;
    add_req.valid && add_req.op != PGD_WRGSR |-> ##2 add_done_q;
  endproperty
  a_add_lat: assert property (p_add_lat)
    else $error("adder done late or missing");
  property p_add_src;
    add_done_q |-> $past(add_req.valid, 2) && $past(add_req.op, 2) != PGD_WRGSR;
  endproperty
  a_add_src: assert property (p_add_src)
    else $error("adder done without request");
  property p_mul_lat;
    mul_req.valid |-> ##4 mul_done_q;
  endproperty
  a_mul_lat: assert property (p_mul_lat)
    else $error("multiplier done late or missing");
  property p_mul_src;
    mul_done_q |-> $past(mul_req.valid, 4);
  endproperty
  a_mul_src: assert property (p_mul_src)
    else $error("multiplier done without request");
  property p_st_lat;
    ls_req.valid && ls_req.store |-> ##2 st_valid_q;
  endproperty
  a_st_lat: assert property (p_st_lat)
    else $error("store data late or missing");
  // Whole-size store: enables cover exactly the access size
  property p_st_be;
    st_valid_q && !$past(ls_req.partial, 2) |-> st_be_q ==
      8'((16'h1 << (8'h1 << $past(ls_req.size, 2))) - 16'h1);
  endproperty
  a_st_be: assert property (p_st_be)
    else $error("store byte enables wrong");
  property p_gsr_src;
    !$stable(gsr_q) |-> $past(add_req.valid, 2) || $past(add_req.valid, 3);
  endproperty
  a_gsr_src: assert property (p_gsr_src)
    else $error("status changed without adder op");
  property p_cmp_hi;
    mul_done_q && $past(mul_req.op, 4) == PGD_CMPGT16 |-> !(|mul_res_q[63:4]);
  endproperty
  a_cmp_hi: assert property (p_cmp_hi)
    else $error("compare result has upper bits set");
  property p_muld_lo;
    mul_done_q && $past(mul_req.op, 4) inside {PGD_MULD8SUX16, PGD_MULD8ULX16}
      |-> mul_res_q[7:0] == 8'h00 && mul_res_q[39:32] == 8'h00;
  endproperty
  a_muld_lo: assert property (p_muld_lo)
    else $error("wide product low byte not zero");
endmodule
`default_nettype wire

/* tb/pgd_issue_model.sv */
// Issue-side model driving the three request slots of the datapath.
// Assumes issue() is entered at a falling clock edge.
`default_nettype none
module pgd_issue_model
  import pgd_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Request slots, 5-bit indices into 32 entries
  output var pgd_add_req_t add_req,
  output var pgd_mul_req_t mul_req,
  output var pgd_ls_req_t ls_req
);
  initial begin
    add_req = '0;
    mul_req = '0;
    ls_req = '0;
  end
  // Two ops and one load or store per cycle
  task automatic issue(input pgd_add_req_t a, input pgd_mul_req_t m,
                       input pgd_ls_req_t l);
    // Idle load data flips so a stale sample cannot pass
    if (!l.valid) l.ld_data = ~ls_req.ld_data;
    add_req = a;
    mul_req = m;
    ls_req = l;
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the partitioned graphics datapath.
// Assumes pgd_pkg, the design and the partner model compile first.
`default_nettype none
module testbench
  import pgd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  wire pgd_add_req_t add_req;
  wire pgd_mul_req_t mul_req;
  wire pgd_ls_req_t ls_req;
  logic add_done_q, mul_done_q, st_valid_q;
  logic [63:0] add_res_q, mul_res_q, st_data_q;
  logic [7:0] st_be_q;
  logic [6:0] gsr_q, egsr;
  int num_errors = 0;
  int n_tests = 0;
  integer seed = 32'h8819fe9f;
  logic [63:0] regs [32];
  logic [63:0] aq [$];
  logic [63:0] mq [$];
  logic [71:0] sq [$];
  pgd_add_req_t na;
  pgd_mul_req_t nm;
  pgd_ls_req_t nl;
  always #2 ref_clk = ~ref_clk;
  pgd_issue_model iss (.ref_clk(ref_clk), .add_req(add_req),
    .mul_req(mul_req), .ls_req(ls_req));
  pgd_datapath uut (.ref_clk(ref_clk), .rst(rst), .add_req(add_req),
    .mul_req(mul_req), .ls_req(ls_req), .add_done_q(add_done_q),
    .add_res_q(add_res_q), .mul_done_q(mul_done_q), .mul_res_q(mul_res_q),
    .st_valid_q(st_valid_q), .st_data_q(st_data_q), .st_be_q(st_be_q),
    .gsr_q(gsr_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [71:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic go();
    iss.issue(na, nm, nl);
    na = '0;
    nm = '0;
    nl = '0;
  endtask
  // Extra edges keep the next read clear of the write-back edge
  task automatic drain();
    // Idle slots first: the model holds its last request otherwise
    go();
    for (int k = 0; k < 20 && aq.size() + mq.size() + sq.size() > 0; k++)
      @(negedge ref_clk);
    if (aq.size() + mq.size() + sq.size() > 0) begin
      num_errors++;
      finish_test();
    end
    repeat (3) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic ld(input logic [4:0] r, input pgd_size_t sz,
                    input logic [63:0] d);
    nl = '{1'b1, 1'b0, sz, 1'b0, 8'h00, r, d};
    regs[r] = d & ((64'h1 << (8 << sz)) - 64'h1 | {64{sz == PGD_SZ64}});
  endtask
  task automatic st(input logic [4:0] r, input pgd_size_t sz, input logic p,
                    input logic [7:0] m);
    logic [7:0] be;
    be = 8'((16'h1 << (8'h1 << sz)) - 16'h1);
    if (p) be = sz == PGD_SZ16 ? {{2{m[3]}}, {2{m[2]}}, {2{m[1]}}, {2{m[0]}}}
      : sz == PGD_SZ32 ? {{4{m[1]}}, {4{m[0]}}} : m;
    nl = '{1'b1, 1'b1, sz, p, m, r, 64'h0};
    sq.push_back({regs[r], be});
  endtask
  task automatic ad(input pgd_add_op_t op, input logic [3:0] f,
                    input logic [4:0] s1, s2, d);
    logic [63:0] a, b, r;
    logic [127:0] c;
    a = regs[s1];
    b = regs[s2];
    r = '0;
    c = {a, b} << (8 * egsr[2:0]);
    for (int i = 0; i < 4; i++) begin
      case (op)
        PGD_ADD16: r[16*i+:16] = a[16*i+:16] + b[16*i+:16];
        PGD_SUB16: r[16*i+:16] = a[16*i+:16] - b[16*i+:16];
        PGD_MERGE: r[16*i+:16] = {a[8*i+:8], b[8*i+:8]};
        PGD_EXPAND: r[16*i+:16] = {4'h0, b[8*i+:8], 4'h0};
        default: ;
      endcase
    end
    for (int j = 0; j < 64; j++) if (op == PGD_LOGIC) r[j] = f[{a[j], b[j]}];
    if (op == PGD_ADD32) r = {a[63:32] + b[63:32], a[31:0] + b[31:0]};
    if (op == PGD_SUB32) r = {a[63:32] - b[63:32], a[31:0] - b[31:0]};
    if (op == PGD_CONV32)
      r = {32'(b[15:8]) << egsr[6:3], 32'(b[7:0]) << egsr[6:3]};
    if (op == PGD_ALIGN) r = c[127:64];
    if (op == PGD_ALIGNADDR) r = (a + b) & ~64'h7;
    if (op == PGD_ALIGNADDR) egsr[2:0] = 3'(a + b);
    if (op == PGD_WRGSR) egsr = a[6:0];
    na = '{1'b1, op, f, s1, s2, d};
    if (op != PGD_WRGSR) aq.push_back(r);
    if (op != PGD_WRGSR) regs[d] = r;
  endtask
  task automatic mu(input pgd_mul_op_t op, input logic [4:0] s1, s2, d);
    logic [63:0] a, b, r;
    int x, y, p, v;
    a = regs[s1];
    b = regs[s2];
    r = op == PGD_PDIST ? regs[d] : '0;
    for (int i = 0; i < 8; i++) if (op == PGD_PDIST) r += a[8*i+:8] > b[8*i+:8]
      ? a[8*i+:8] - b[8*i+:8] : b[8*i+:8] - a[8*i+:8];
    for (int i = 0; i < 4; i++) begin
      y = $signed(op == PGD_MUL8X16AU ? b[31:16] : op == PGD_MUL8X16AL ?
        b[15:0] : b[16*i+:16]);
      x = op inside {PGD_MUL8SUX16, PGD_MULD8SUX16}
        ? int'($signed(a[16*i+8+:8]))
        : op inside {PGD_MUL8ULX16, PGD_MULD8ULX16} ? a[16*i+:8] : a[8*i+:8];
      p = x * y;
      v = (y <<< egsr[6:3]) >>> 7;
      if (op == PGD_CMPGT16) r[i] = $signed(a[16*i+:16]) > $signed(b[16*i+:16]);
      else if (op > PGD_MUL8ULX16 && op < PGD_PDIST && i < 2)
        r[32*i+:32] = {p[23:0], 8'h00};
      else if (op < PGD_MULD8SUX16) r[16*i+:16] = 16'((p + 128) >>> 8);
      else if (op == PGD_PACK16)
        r[8*i+:8] = v < 0 ? 8'h00 : v > 255 ? 8'hff : 8'(v);
    end
    nm = '{1'b1, op, s1, s2, d};
    mq.push_back(r);
    regs[d] = r;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk) begin
    if (add_done_q === 1'b1)
      check("add_res", add_res_q, aq.size() ? aq.pop_front() : 'x);
    if (mul_done_q === 1'b1)
      check("mul_res", mul_res_q, mq.size() ? mq.pop_front() : 'x);
    if (st_valid_q === 1'b1)
      check("store", {st_data_q, st_be_q}, sq.size() ? sq.pop_front() : 'x);
  end
  initial begin
    na = '0;
    nm = '0;
    nl = '0;
    egsr = 7'h00;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check("gsr_reset", gsr_q, 7'h00);
    for (int r = 1; r < 7; r++) begin
      ld(5'(r), PGD_SZ64, {$random(seed), $random(seed)});
      go();
    end
    // All-ones against one: every lane carries out
    ld(7, PGD_SZ64, 64'hffff_ffff_ffff_ffff);
    go();
    ld(8, PGD_SZ64, 64'h0001_0001_0001_0001);
    go();
    for (int s = 0; s < 4; s++) begin
      ld(5'(9 + s), pgd_size_t'(2'(s)), {$random(seed), $random(seed)});
      go();
    end
    drain();
    for (int s = 0; s < 8; s++) begin
      st(s < 4 ? 5'(9 + s) : 5'd2, pgd_size_t'(2'(s)), s > 3, 8'($random(seed)));
      go();
    end
    for (int k = 0; k < 8; k++) begin
      ad(pgd_add_op_t'(4'(k % 4)), 4'h0, k < 4 ? (k % 2 ? 5'd8 : 5'd7) : 5'd1,
        k < 4 ? (k % 2 ? 5'd7 : 5'd8) : 5'd2, 5'(16 + k));
      if (k == 0) mu(PGD_PDIST, 1, 2, 9);
      go();
    end
    ad(PGD_MERGE, 4'h0, 1, 2, 0);
    go();
    ad(PGD_EXPAND, 4'h0, 1, 2, 13);
    go();
    ad(PGD_CONV32, 4'h0, 1, 2, 14);
    go();
    // Logic functions alongside every multiply variant and a store
    for (int f = 0; f < 16; f++) begin
      ad(PGD_LOGIC, 4'(f), 1, 2, 15);
      if (f < 7) mu(pgd_mul_op_t'(4'(f)), 3, 4, 5'(24 + f));
      if (f == 7) mu(PGD_CMPGT16, 7, 1, 31);
      if (f == 8) mu(PGD_PACK16, 3, 4, 23);
      if (f == 0) st(3, PGD_SZ64, 1'b0, 8'h00);
      go();
    end
    drain();
    ad(PGD_ALIGNADDR, 4'h0, 5, 6, 10);
    go();
    drain();
    check("gsr_align", gsr_q, egsr);
    ad(PGD_ALIGN, 4'h0, 1, 2, 11);
    go();
    ad(PGD_WRGSR, 4'h0, 4, 0, 0);
    go();
    drain();
    check("gsr_write", gsr_q, egsr);
    // Scale now non-zero: pack and conversion shift by it
    mu(PGD_PACK16, 5, 6, 22);
    ad(PGD_CONV32, 4'h0, 1, 2, 21);
    go();
    drain();
    finish_test();
  end
endmodule
bind pgd_datapath pgd_dp_properties u_chk (.ref_clk(ref_clk), .rst(rst),
  .add_req(add_req), .mul_req(mul_req), .ls_req(ls_req),
  .add_done_q(add_done_q), .add_res_q(add_res_q), .mul_done_q(mul_done_q),
  .mul_res_q(mul_res_q), .st_valid_q(st_valid_q), .st_data_q(st_data_q),
  .st_be_q(st_be_q), .gsr_q(gsr_q));
`default_nettype wire
